//--- wwdt_top.sv
// Window watchdog: kick window check and open-drain fault output
//
// Operation
// (R01) With the delay pin open the fault lasts the factory delay, nominally 200 ms within 170 to 230 ms.
// (R02) A missing kick by the upper bound holds the fault low for the reset delay, then re-arms.
// (R03) Once kicks land inside the window the fault output stays released.
// (R04) Selects both high give nominal bounds of 800 ms and 1.6 s.
// (R05) Selects both high keep the lower bound at most 920 ms and the upper at least 1360 ms.
// (R06) Selects both low keep the lower bound at most 25.9 ms and the upper at least 46.8 ms.
// (R07) A kick before the lower bound or after the upper bound raises a fault.
// (R08) The fault pin is open drain: pulled low when active, released otherwise.
// (R09) The delay pin selects capacitor, pull-up or open; the last two give the factory delay.
// (R10) The processor places each kick strictly inside the configured window.
// (R11) The falling edge of the kick input is the event checked against the window.
// (R12) Window timing restarts at each valid kick and at the end of each fault.
// (R13) With a capacitor the delay is a fixed offset plus a time proportional to capacitance.
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter int unsigned FACTORY_DLY_CYC = RST_TYP_CYC,
  parameter int unsigned DLY_INIT_CYC    = INIT_CYC,
  parameter int unsigned WDL_SEL00_CYC   = WDL_00_CYC,
  parameter int unsigned WDU_SEL00_CYC   = WDU_00_CYC,
  parameter int unsigned WDL_SEL01_CYC   = WDL_01_CYC,
  parameter int unsigned WDU_SEL01_CYC   = WDU_01_CYC,
  parameter int unsigned WDL_SEL10_CYC   = WDL_10_CYC,
  parameter int unsigned WDU_SEL10_CYC   = WDU_10_CYC,
  parameter int unsigned WDL_SEL11_CYC   = WDL_11_CYC,
  parameter int unsigned WDU_SEL11_CYC   = WDU_11_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             kick_input,
  input  wire logic             window_select_lo,
  input  wire logic             window_select_hi,
  input  wire logic [1:0]       delay_program_pin,
  input  wire logic [CAP_W-1:0] delay_cap_pf,
  input  wire logic             fault_output_n_i,
  output logic                  fault_output_n_o,
  output logic                  fault_output_n_oe,
  output logic [1:0]            fault_cause
);

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  typedef enum logic {WWDT_WATCH, WWDT_FAULT} wwdt_state_type;

  function automatic logic [CNT_W-1:0] wwdt_bound(input logic [1:0] sel, input logic upper);
    logic [CNT_W-1:0] v;
    v = '0;
    unique case (sel)
      2'h0: v = upper ? CNT_W'(WDU_SEL00_CYC) : CNT_W'(WDL_SEL00_CYC); // R06
      2'h1: v = upper ? CNT_W'(WDU_SEL01_CYC) : CNT_W'(WDL_SEL01_CYC);
      2'h2: v = upper ? CNT_W'(WDU_SEL10_CYC) : CNT_W'(WDL_SEL10_CYC);
      2'h3: v = upper ? CNT_W'(WDU_SEL11_CYC) : CNT_W'(WDL_SEL11_CYC); // R05
    endcase
    return v;
  endfunction : wwdt_bound

  wire logic [1:0]       sel_w       = {window_select_hi, window_select_lo};
  wire logic [CNT_W-1:0] lower_cyc_w = wwdt_bound(sel_w, 1'b0); // R04
  wire logic [CNT_W-1:0] upper_cyc_w = wwdt_bound(sel_w, 1'b1); // R04
  wire logic [CNT_W-1:0] cap_cyc_w   = CNT_W'(delay_cap_pf) * CNT_W'(CYC_PER_PF);
  wire logic [CNT_W-1:0] delay_cyc_w = (delay_program_pin == WWDT_DLY_CAP)
                                       ? CNT_W'(DLY_INIT_CYC) + cap_cyc_w // R13
                                       : CNT_W'(FACTORY_DLY_CYC); // R01 R09

  // ----------------------------------------------------------------
  // Kick edge and window checks
  // ----------------------------------------------------------------
  logic                  kick_prev_r;
  logic [CNT_W-1:0]      timer_r;
  logic [CNT_W-1:0]      timer_nxt;
  logic                  fault_r;
  logic [1:0]            cause_r;
  wwdt_state_type        state_r;
  wwdt_state_type        state_nxt;

  wire logic kick_fall_w = kick_prev_r & ~kick_input; // R11
  wire logic watching_w  = (state_r == WWDT_WATCH);
  wire logic early_w     = watching_w & kick_fall_w & (timer_r < lower_cyc_w); // R07
  wire logic late_w      = watching_w & ~kick_fall_w & (timer_r >= upper_cyc_w); // R02 R07
  wire logic valid_w     = watching_w & kick_fall_w & ~early_w; // R03
  wire logic dly_done_w  = (state_r == WWDT_FAULT) & (timer_r >= delay_cyc_w - CNT_W'(1));

  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r + CNT_W'(1);
    unique case (state_r)
      WWDT_WATCH: begin
        if (early_w || late_w) begin
          state_nxt = WWDT_FAULT;
          timer_nxt = '0;
        end else if (valid_w) begin
          timer_nxt = '0; // R12
        end
      end
      WWDT_FAULT: begin
        if (dly_done_w) begin
          state_nxt = WWDT_WATCH; // R02
          timer_nxt = '0; // R12
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      kick_prev_r <= 1'b0;
      timer_r     <= '0;
      state_r     <= WWDT_WATCH;
    end else begin
      kick_prev_r <= kick_input;
      timer_r     <= timer_nxt;
      state_r     <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain fault output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_r <= 1'b0;
      cause_r <= CAUSE_NONE;
    end else begin
      fault_r <= (state_nxt == WWDT_FAULT); // R02 R07
      if (early_w) begin
        cause_r <= CAUSE_EARLY;
      end else if (late_w) begin
        cause_r <= CAUSE_LATE;
      end
    end
  end

  assign fault_output_n_o  = 1'b0; // R08
  assign fault_output_n_oe = fault_r; // R08
  assign fault_cause       = cause_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking wwdt_cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  logic [CNT_W-1:0] fault_len_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_len_r <= '0;
    end else begin
      fault_len_r <= fault_r ? fault_len_r + CNT_W'(1) : '0;
    end
  end

  property p_open_delay;
    (delay_program_pin == WWDT_DLY_OPEN) |-> (delay_cyc_w == CNT_W'(FACTORY_DLY_CYC));
  endproperty
  a_open_delay: assert property (p_open_delay) else $error("open delay pin not factory delay"); // R01

  property p_fault_length;
    $fell(fault_r) && $stable(delay_cyc_w) |-> ($past(fault_len_r) == delay_cyc_w - CNT_W'(1));
  endproperty
  a_fault_length: assert property (p_fault_length) else $error("fault held wrong length"); // R02

  property p_late_fault;
    late_w |=> fault_r && !fault_output_n_o;
  endproperty
  a_late_fault: assert property (p_late_fault) else $error("timeout did not raise fault"); // R02

  property p_good_kick;
    valid_w && !fault_r |=> !fault_r && (timer_r == '0);
  endproperty
  a_good_kick: assert property (p_good_kick) else $error("in-window kick disturbed output"); // R03 R12

  property p_sel11_nominal;
    (sel_w == 2'h3) |-> (lower_cyc_w == CNT_W'(WDL_SEL11_CYC)) && (upper_cyc_w == CNT_W'(WDU_SEL11_CYC));
  endproperty
  a_sel11_nominal: assert property (p_sel11_nominal) else $error("select 11 bounds wrong"); // R04

  // Limits scale with the configured nominal bound, so shortened builds stay checkable
  property p_sel11_limits;
    (sel_w == 2'h3) |->
      (64'(lower_cyc_w) * 64'(T_WDL_11_US) <= 64'(WDL_SEL11_CYC) * 64'(T_WDL_11_LIM_US)) &&
      (64'(upper_cyc_w) * 64'(T_WDU_11_US) >= 64'(WDU_SEL11_CYC) * 64'(T_WDU_11_LIM_US));
  endproperty
  a_sel11_limits: assert property (p_sel11_limits) else $error("select 11 bounds out of limits"); // R05

  property p_sel00_limits;
    (sel_w == 2'h0) |->
      (64'(lower_cyc_w) * 64'(T_WDL_00_US) <= 64'(WDL_SEL00_CYC) * 64'(T_WDL_00_LIM_US)) &&
      (64'(upper_cyc_w) * 64'(T_WDU_00_US) >= 64'(WDU_SEL00_CYC) * 64'(T_WDU_00_LIM_US));
  endproperty
  a_sel00_limits: assert property (p_sel00_limits) else $error("select 00 bounds out of limits"); // R06

  property p_early_fault;
    watching_w && $fell(kick_input) && (timer_r < lower_cyc_w) |=> fault_r ##1 fault_r;
  endproperty
  a_early_fault: assert property (p_early_fault) else $error("early kick did not raise fault"); // R07

  property p_open_drain;
    fault_output_n_o == 1'b0 && (fault_output_n_oe == (state_r == WWDT_FAULT));
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("fault pin drives high or enable wrong"); // R08

  property p_pin_low;
    fault_output_n_oe |-> !fault_output_n_i;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("fault pin not low while driven"); // R08

  property p_pullup_delay;
    (delay_program_pin == WWDT_DLY_PULLUP) |-> (delay_cyc_w == CNT_W'(FACTORY_DLY_CYC));
  endproperty
  a_pullup_delay: assert property (p_pullup_delay) else $error("pull-up delay not factory delay"); // R09

  property p_edge_only;
    watching_w && !(kick_prev_r && !kick_input) && (timer_r < upper_cyc_w) |=> !fault_r;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("fault without kick edge or timeout"); // R11

  property p_rearm;
    dly_done_w |=> !fault_r && (timer_r == '0) && watching_w;
  endproperty
  a_rearm: assert property (p_rearm) else $error("window did not restart after fault"); // R12

  property p_cap_delay;
    (delay_program_pin == WWDT_DLY_CAP) |->
      (delay_cyc_w == CNT_W'(DLY_INIT_CYC) + CNT_W'(delay_cap_pf) * CNT_W'(CYC_PER_PF));
  endproperty
  a_cap_delay: assert property (p_cap_delay) else $error("capacitor delay not offset plus charge"); // R13

endmodule : wwdt_top

//--- wwdt_pkg.sv
// Constants for the window watchdog timer
package wwdt_pkg;

  // ----------------------------------------------------------------
  // Clock and counter widths
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned CNT_W   = 32;
  localparam int unsigned CAP_W   = 20;

  // ----------------------------------------------------------------
  // Delay pin strap encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WWDT_DLY_OPEN   = 2'h0,
    WWDT_DLY_PULLUP = 2'h1,
    WWDT_DLY_CAP    = 2'h2
  } wwdt_dly_mode_type;

  // ----------------------------------------------------------------
  // Reset delay timing (microseconds, then cycles)
  // ----------------------------------------------------------------
  localparam int unsigned T_RST_MIN_US      = 170000;
  localparam int unsigned T_RST_TYP_US      = 200000;
  localparam int unsigned T_RST_MAX_US      = 230000;
  localparam int unsigned RST_TYP_CYC       = T_RST_TYP_US * CLK_MHZ;
  localparam int unsigned RST_MIN_CYC       = T_RST_MIN_US * CLK_MHZ;
  localparam int unsigned RST_MAX_CYC       = T_RST_MAX_US * CLK_MHZ;
  localparam int unsigned T_INIT_US         = 1000;
  localparam int unsigned INIT_CYC          = T_INIT_US * CLK_MHZ;
  localparam int unsigned CYC_PER_PF        = 10;

  // ----------------------------------------------------------------
  // Window bounds per select code (microseconds, then cycles)
  // ----------------------------------------------------------------
  localparam int unsigned T_WDL_00_US     = 20000;
  localparam int unsigned T_WDU_00_US     = 50000;
  localparam int unsigned T_WDL_01_US     = 150000;
  localparam int unsigned T_WDU_01_US     = 200000;
  localparam int unsigned T_WDL_10_US     = 400000;
  localparam int unsigned T_WDU_10_US     = 800000;
  localparam int unsigned T_WDL_11_US     = 800000;
  localparam int unsigned T_WDU_11_US     = 1600000;
  localparam int unsigned WDL_00_CYC      = T_WDL_00_US * CLK_MHZ;
  localparam int unsigned WDU_00_CYC      = T_WDU_00_US * CLK_MHZ;
  localparam int unsigned WDL_01_CYC      = T_WDL_01_US * CLK_MHZ;
  localparam int unsigned WDU_01_CYC      = T_WDU_01_US * CLK_MHZ;
  localparam int unsigned WDL_10_CYC      = T_WDL_10_US * CLK_MHZ;
  localparam int unsigned WDU_10_CYC      = T_WDU_10_US * CLK_MHZ;
  localparam int unsigned WDL_11_CYC      = T_WDL_11_US * CLK_MHZ;
  localparam int unsigned WDU_11_CYC      = T_WDU_11_US * CLK_MHZ;

  // Limits the lower bound may not exceed / upper bound may not undercut
  localparam int unsigned T_WDL_00_LIM_US = 25900;
  localparam int unsigned T_WDU_00_LIM_US = 46800;
  localparam int unsigned T_WDL_11_LIM_US = 920000;
  localparam int unsigned T_WDU_11_LIM_US = 1360000;
  localparam int unsigned WDL_00_LIM_CYC  = T_WDL_00_LIM_US * CLK_MHZ;
  localparam int unsigned WDU_00_LIM_CYC  = T_WDU_00_LIM_US * CLK_MHZ;
  localparam int unsigned WDL_11_LIM_CYC  = T_WDL_11_LIM_US * CLK_MHZ;
  localparam int unsigned WDU_11_LIM_CYC  = T_WDU_11_LIM_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Fault cause codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CAUSE_NONE  = 2'h0;
  localparam logic [1:0] CAUSE_EARLY = 2'h1;
  localparam logic [1:0] CAUSE_LATE  = 2'h2;

endpackage : wwdt_pkg

//--- wwdt_kicker.sv
// Processor model that issues watchdog kicks at a set spacing
`timescale 1ns/1ps
module wwdt_kicker (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        run,
  input  wire logic [15:0] gap,
  output logic             kick_input
);
  logic [15:0] cnt_r;
  // ------------------------------------------------------------
  // Kick generator
  // ------------------------------------------------------------
  // One-cycle low pulse every gap cycles, line high between kicks
  always_ff @(negedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r      <= 16'h0000;
      kick_input <= 1'b1;
    end else if (!run) begin
      cnt_r      <= 16'h0000;
      kick_input <= 1'b1;
    end else begin
      cnt_r      <= (cnt_r == gap - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
      kick_input <= (cnt_r != gap - 16'h0001);
    end
  end
endmodule : wwdt_kicker

//--- wwdt_bench.sv
// Self-checking testbench for the window watchdog
`timescale 1ns/1ps
module wwdt_bench;
  import wwdt_pkg::*;
  // ------------------------------------------------------------
  // Shortened timing and signals
  // ------------------------------------------------------------
  localparam int unsigned DLY = 50;
  localparam int unsigned INI = 5;
  localparam int unsigned LO [4] = '{20, 30, 40, 60};
  localparam int unsigned UP [4] = '{40, 50, 60, 90};
  logic             core_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             kick_input;
  logic             window_select_lo = 1'b0;
  logic             window_select_hi = 1'b0;
  logic [1:0]       delay_program_pin = 2'h0;
  logic [CAP_W-1:0] delay_cap_pf = 20'h00003;
  logic             fault_output_n_o;
  logic             fault_output_n_oe;
  logic [1:0]       fault_cause;
  logic             run = 1'b0;
  logic [15:0]      gap = 16'h0010;
  wire              fault_pin;
  int               fails = 0;
  int               n_compared = 0;
  int               n;
  // Pull-up holds the pin high unless the device sinks it
  assign fault_pin = fault_output_n_oe ? fault_output_n_o : 1'b1;
  always #50 core_clk = ~core_clk;
  wwdt_top #(.FACTORY_DLY_CYC(DLY), .DLY_INIT_CYC(INI),
    .WDL_SEL00_CYC(LO[0]), .WDU_SEL00_CYC(UP[0]), .WDL_SEL01_CYC(LO[1]), .WDU_SEL01_CYC(UP[1]),
    .WDL_SEL10_CYC(LO[2]), .WDU_SEL10_CYC(UP[2]), .WDL_SEL11_CYC(LO[3]), .WDU_SEL11_CYC(UP[3])) dut (
    .core_clk(core_clk), .reset_n(reset_n), .kick_input(kick_input), .window_select_lo(window_select_lo),
    .window_select_hi(window_select_hi), .delay_program_pin(delay_program_pin), .delay_cap_pf(delay_cap_pf),
    .fault_output_n_i(fault_pin), .fault_output_n_o(fault_output_n_o), .fault_output_n_oe(fault_output_n_oe),
    .fault_cause(fault_cause));
  wwdt_kicker partner (.core_clk(core_clk), .reset_n(reset_n), .run(run), .gap(gap), .kick_input(kick_input));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check
  task automatic do_reset(input int sel, input logic [1:0] mode, input int g, input logic go);
    @(negedge core_clk);
    reset_n = 1'b0;
    run = 1'b0;
    {window_select_hi, window_select_lo} = sel[1:0];
    delay_program_pin = mode;
    gap = g[15:0];
    repeat (8) @(negedge core_clk);
    reset_n <= 1'b1;
    run     <= go;
  endtask : do_reset
  task automatic wait_oe(input logic lvl, output int cnt);
    cnt = 0;
    while (fault_output_n_oe !== lvl) begin
      @(negedge core_clk);
      cnt++;
      if (cnt > 400) begin
        fails++;
        $display("CHECK FAILED wait for fault level %0d", lvl);
        print_verdict();
      end
    end
  endtask : wait_oe
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_timeout();
    for (int s = 0; s < 4; s++) begin
      do_reset(s, WWDT_DLY_OPEN, 16, 1'b0);
      check("cause after reset", fault_cause, CAUSE_NONE);
      check("pin idle high", fault_pin, 1);
      wait_oe(1'b1, n);
      check("time to timeout", n >= UP[s] - 1 && n <= UP[s] + 1, 1);
      check("cause late", fault_cause, CAUSE_LATE);
      check("pin low", fault_pin, 0);
      check("drive level", fault_output_n_o, 0);
      wait_oe(1'b0, n);
      check("fault length", n, DLY);
      check("pin released", fault_pin, 1);
      wait_oe(1'b1, n);
      check("rearm time", n >= UP[s] - 1 && n <= UP[s] + 1, 1);
    end
  endtask : t_timeout
  task automatic t_delay_modes();
    logic [1:0] md [3] = '{WWDT_DLY_OPEN, WWDT_DLY_PULLUP, WWDT_DLY_CAP};
    int         ex [3] = '{DLY, DLY, INI + 3 * CYC_PER_PF};
    for (int m = 0; m < 3; m++) begin
      do_reset(0, md[m], 16, 1'b0);
      wait_oe(1'b1, n);
      wait_oe(1'b0, n);
      check("delay by strap", n, ex[m]);
    end
  endtask : t_delay_modes
  task automatic t_window();
    int hi;
    for (int s = 0; s < 4; s++) begin
      do_reset(s, WWDT_DLY_OPEN, LO[s] / 2, 1'b1);
      wait_oe(1'b1, n);
      check("early kick time", n >= LO[s] / 2 - 1 && n <= LO[s] / 2 + 2, 1);
      check("cause early", fault_cause, CAUSE_EARLY);
      do_reset(s, WWDT_DLY_OPEN, (LO[s] + UP[s]) / 2, 1'b1);
      hi = 0;
      repeat (6 * UP[s]) begin
        @(negedge core_clk);
        if (fault_output_n_oe !== 1'b0) hi++;
      end
      check("in window quiet", hi, 0);
    end
  endtask : t_window
  task automatic t_recover();
    int hi;
    do_reset(3, WWDT_DLY_OPEN, 75, 1'b0);
    repeat (3) begin
      wait_oe(1'b1, n);
      wait_oe(1'b0, n);
    end
    run <= 1'b1;
    hi = 0;
    repeat (600) begin
      @(negedge core_clk);
      if (fault_pin !== 1'b1) hi++;
    end
    check("stays released", hi, 0);
  endtask : t_recover
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    t_timeout();
    t_delay_modes();
    t_window();
    t_recover();
    print_verdict();
  end
endmodule : wwdt_bench
